// ### core/diag_pkg.sv
package diag_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [5:0] OFS_CTRL = 6'h00; // global enables
	localparam logic [5:0] OFS_STATUS = 6'h04; // flags and codes
	localparam logic [5:0] OFS_CFG0 = 6'h08; // block 0 config
	localparam logic [5:0] OFS_THR0 = 6'h18; // block 0 threshold lo/hi
	localparam logic [5:0] OFS_REQ = 6'h28; // request strobes
	localparam logic [5:0] OFS_DTC0 = 6'h2C; // block 0 dtc readback
	localparam int NBLK = 4; // fault sources
	localparam int BLK_SUPPLY = 0;
	localparam int BLK_TEMP = 1;
	localparam int BLK_COMM = 2;
	localparam int BLK_OUT = 3;
	// cfg word field positions
	localparam int CFG_SPN_LSB = 0; // 19-bit spn
	localparam int CFG_FMI_LSB = 19; // 5-bit fmi
	localparam int CFG_LAMP_LSB = 24; // 2-bit lamp select
	localparam int CFG_GEN_BIT = 26; // generate messages
	localparam int CFG_LATCH_BIT = 27; // latch_until_clear_request
	localparam int CFG_EN_BIT = 28; // block enabled
	// ctrl bits
	localparam int CTRL_PWR_OFF_BIT = 0; // supply fault disables output
	localparam int CTRL_TEMP_OFF_BIT = 1; // over temp disables output
	// request bits
	localparam int REQ_DM2_BIT = 0;
	localparam int REQ_DM3_BIT = 1;
	localparam int REQ_DM11_BIT = 2;
	// fmi constants
	localparam logic [4:0] FMI_CM_ZERO = 5'h00; // unused helper
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] THR_RST = 32'h0000_0000;
	localparam logic [7:0] OC_MAX = 8'h7E; // occurrence count saturates
	// timing
	localparam longint CLK_HZ = 250000000;
	localparam longint PERIOD_MS = 1000; // broadcast period
	localparam longint HOLDOFF_MS = 5000; // power-up suppression
	localparam longint PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
	localparam longint HOLDOFF_CYC = CLK_HZ / 1000 * HOLDOFF_MS;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SINGLE = 3'b010,
		TX_MULTI = 3'b100
	} tx_state_type;
endpackage

// ### core/fault_diag_manager.sv
`timescale 1ns/1ps
module fault_diag_manager #(
	parameter int VW = 16, // measurement width
	parameter int TW = 24, // timer width
	parameter longint HOLDOFF = diag_pkg::HOLDOFF_CYC, // power-up hold-off
	parameter longint PERIOD = diag_pkg::PERIOD_CYC // broadcast period
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic [5:0] adr_i, // wishbone byte address
	input wire logic [31:0] dat_i, // wishbone write data
	input wire logic [3:0] sel_i, // byte enables
	input wire logic we_i, // write enable
	input wire logic cyc_i, // cycle
	input wire logic stb_i, // strobe
	output logic [31:0] dat_o, // read data
	output logic ack_o, // acknowledge
	input wire logic [VW-1:0] supply_i, // measured supply
	input wire logic [VW-1:0] temp_i, // measured temperature
	input wire logic [VW-1:0] target_i, // output target
	input wire logic [VW-1:0] feedback_i, // measured feedback
	input wire logic rx_seen_i, // expected message arrived, pulse
	input wire logic tx_busy_i, // transport busy with a message
	output logic out_disable_o, // force pulse output off
	output logic dm1_send_o, // pulse: send active-code msg
	output logic dm1_multi_o, // message needs transport protocol
	output logic dm2_send_o, // pulse: send prev-active list
	output logic [7:0] lamp_o, // lamp byte of message
	output logic [3:0] active_o, // active code per block
	output logic [3:0] prev_o // previously active per block
);
	import diag_pkg::*;

	logic [31:0] cfg_r [NBLK]; // per-block config words
	logic [31:0] thr_r [NBLK]; // lo/band in [15:0], hi in [31:16]
	logic [31:0] tmo_r; // reception timeout, cycles
	logic [1:0] ctrl_r; // output disable enables
	logic [7:0] oc_r [NBLK]; // occurrence counts
	logic [TW-1:0] pt_r [NBLK]; // fault_persist_timer per block
	logic [3:0] raw_r; // qualified raw fault flag
	logic [3:0] hi_r; // high occurrence side
	logic [3:0] act_r; // active codes
	logic [3:0] prv_r; // previously active
	logic [31:0] rxc_r; // reception age counter
	logic [63:0] hold_r; // hold-off counter
	logic [63:0] per_r; // period counter
	logic hold_done_r; // hold-off elapsed
	logic had_act_r; // any active last cycle
	logic pend_r; // send owed after a back-to-back request
	logic [2:0] req_r; // request pulse from bus
	tx_state_type tx_r;
	logic wr; // bus write this cycle
	logic [3:0] raw_nxt;
	logic [3:0] hi_nxt;

	// pair a low-side fmi to its high-side partner
	function automatic logic [4:0] high_fmi(input logic [4:0] f);
		case (f)
			5'h01: high_fmi = 5'h00;
			5'h04: high_fmi = 5'h03;
			5'h05: high_fmi = 5'h06;
			5'h11: high_fmi = 5'h0F;
			5'h12: high_fmi = 5'h10;
			5'h15: high_fmi = 5'h14;
			default: high_fmi = f;
		endcase
	endfunction

	// fmi actually reported; invalid codes fall back to default
	function automatic logic [4:0] eff_fmi(input int b, input logic [4:0] f,
			input logic hi);
		logic [4:0] d;
		d = (b == BLK_SUPPLY) ? 5'h04 : (b == BLK_TEMP) ? 5'h00 :
			(b == BLK_COMM) ? 5'h09 : 5'h07;
		if (f > 5'h15 && f != 5'h1F) begin
			f = d;
		end
		eff_fmi = hi ? high_fmi(f) : f;
	endfunction

	// absolute difference, used for the output check
	function automatic logic [VW-1:0] absdiff(input logic [VW-1:0] a,
			input logic [VW-1:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	assign wr = cyc_i & stb_i & we_i & ~ack_o;

	// wishbone slave: one wait state, ack one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			if (cyc_i & stb_i & ~we_i & ~ack_o) begin
				if (adr_i == OFS_CTRL) begin
					dat_o <= {30'h0000_0000, ctrl_r};
				end else if (adr_i == OFS_STATUS) begin
					dat_o <= {16'h0000, hi_r, raw_r, prv_r, act_r};
				end else if (adr_i >= OFS_CFG0 && adr_i < OFS_THR0) begin
					// cfg words start at word 2, so rebase the index
					dat_o <= cfg_r[adr_i[3:2]-2'd2];
				end else if (adr_i >= OFS_THR0 && adr_i < OFS_REQ) begin
					dat_o <= thr_r[adr_i[3:2] - 2'd2];
				end else if (adr_i == 6'h3C) begin
					dat_o <= tmo_r;
				end else if (adr_i >= OFS_DTC0 && adr_i < 6'h3C) begin
					// spn, fmi, cm fixed 0, count
					// high occurrence shows its paired fmi
					dat_o <= {cfg_r[adr_i[3:2]-2'd3][18:0],
						eff_fmi(int'(2'(adr_i[3:2]-2'd3)),
						cfg_r[adr_i[3:2]-2'd3][23:19],
						hi_r[adr_i[3:2]-2'd3]),
						1'b0, oc_r[adr_i[3:2]-2'd3][6:0]};
				end else begin
					dat_o <= 32'h0000_0000; // unmapped reads zero
				end
			end
		end
	end

	// configuration writes; byte enables respected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= 2'b00;
			tmo_r <= 32'h0000_0000;
			for (int i = 0; i < NBLK; i++) begin
				cfg_r[i] <= CFG_RST;
				thr_r[i] <= THR_RST;
			end
		end else if (wr) begin
			for (int k = 0; k < 4; k++) begin
				if (sel_i[k]) begin
					if (adr_i == OFS_CTRL && k == 0) begin
						ctrl_r <= dat_i[1:0];
					end else if (adr_i == 6'h3C) begin
						tmo_r[k*8 +: 8] <= dat_i[k*8 +: 8];
					end else if (adr_i >= OFS_CFG0 && adr_i < OFS_THR0) begin
						cfg_r[adr_i[3:2]-2'd2][k*8 +: 8] <= dat_i[k*8 +: 8];
					end else if (adr_i >= OFS_THR0 && adr_i < OFS_REQ) begin
						thr_r[adr_i[3:2]-2'd2][k*8 +: 8] <= dat_i[k*8 +: 8];
					end
				end
			end
		end
	end

	// request strobes pulse one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_r <= 3'b000;
		end else begin
			req_r <= (wr && adr_i == OFS_REQ && sel_i[0]) ? dat_i[2:0] : 3'b000;
		end
	end

	// reception age; zero timeout means never stale
	always_ff @(posedge clk_i) begin
		if (rst_i || rx_seen_i) begin
			rxc_r <= 32'h0000_0000;
		end else if (rxc_r != 32'hFFFF_FFFF) begin
			rxc_r <= rxc_r + 32'h0000_0001;
		end
	end

	// raw condition detection; supply and temperature release with hysteresis
	always_comb begin
		logic [VW-1:0] lo;
		logic [VW-1:0] hi;
		logic [VW-1:0] band;
		lo = thr_r[BLK_SUPPLY][VW-1:0];
		hi = thr_r[BLK_SUPPLY][16 +: VW];
		band = thr_r[BLK_OUT][VW-1:0];
		raw_nxt = raw_r;
		hi_nxt = hi_r;
		// low or high supply with band to clear
		if (supply_i < lo) begin
			raw_nxt[BLK_SUPPLY] = 1'b1;
			hi_nxt[BLK_SUPPLY] = 1'b0;
		end else if (supply_i > hi) begin
			raw_nxt[BLK_SUPPLY] = 1'b1;
			hi_nxt[BLK_SUPPLY] = 1'b1;
		end else if (supply_i >= lo + band && supply_i + band <= hi) begin
			raw_nxt[BLK_SUPPLY] = 1'b0;
		end
		hi = thr_r[BLK_TEMP][16 +: VW];
		if (temp_i > hi) begin
			raw_nxt[BLK_TEMP] = 1'b1;
		end else if (temp_i + band <= hi) begin
			raw_nxt[BLK_TEMP] = 1'b0;
		end
		hi_nxt[BLK_TEMP] = 1'b1;
		raw_nxt[BLK_COMM] = (tmo_r != 32'h0000_0000) && (rxc_r >= tmo_r);
		hi_nxt[BLK_COMM] = 1'b0;
		raw_nxt[BLK_OUT] = absdiff(feedback_i, target_i) > band;
		hi_nxt[BLK_OUT] = feedback_i > target_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_r <= 4'h0;
			hi_r <= 4'h0;
		end else begin
			raw_r <= raw_nxt;
			hi_r <= hi_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_r <= 4'h0;
			prv_r <= 4'h0;
			for (int i = 0; i < NBLK; i++) begin
				pt_r[i] <= '0;
				oc_r[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < NBLK; i++) begin
				// previous list cleared only by request
				// placed first so a same-cycle set wins
				if (req_r[REQ_DM3_BIT]) begin
					prv_r[i] <= 1'b0;
				end
				if (!cfg_r[i][CFG_EN_BIT] || !raw_r[i]) begin
					pt_r[i] <= thr_r[i][31 -: TW];
					if (act_r[i] && !cfg_r[i][CFG_LATCH_BIT]) begin
						act_r[i] <= 1'b0;
						prv_r[i] <= 1'b1;
					end
				end else if (!act_r[i]) begin
					if (pt_r[i] == '0) begin
						act_r[i] <= 1'b1;
						if (oc_r[i] != OC_MAX) begin
							oc_r[i] <= oc_r[i] + 8'h01;
						end
					end else begin
						pt_r[i] <= pt_r[i] - TW'(1);
					end
				end
				if (req_r[REQ_DM11_BIT] && !(raw_r[i] && cfg_r[i][CFG_EN_BIT])) begin
					if (act_r[i]) begin
						act_r[i] <= 1'b0;
						prv_r[i] <= 1'b1;
					end
				end
				if (wr && adr_i[5:2] == 4'(i + 2) && (sel_i[2:0] != 3'b000)) begin
					oc_r[i] <= 8'h00;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_r <= 64'h0;
			hold_done_r <= 1'b0;
			per_r <= 64'h0;
		end else begin
			if (!hold_done_r) begin
				hold_r <= hold_r + 64'h1;
				hold_done_r <= (hold_r >= 64'(HOLDOFF - 1));
			end
			per_r <= (per_r >= 64'(PERIOD - 1)) ? 64'h0 : per_r + 64'h1;
		end
	end

	// broadcast scheduling and message attributes
	always_ff @(posedge clk_i) begin
		logic gen;
		logic go;
		int n;
		gen = 1'b0;
		n = 0;
		for (int i = 0; i < NBLK; i++) begin
			gen = gen | cfg_r[i][CFG_GEN_BIT];
			n = n + int'(act_r[i]);
		end
		// periodic, new code, or last cleared
		go = gen && hold_done_r && ((per_r == 64'h0) ||
			(|(act_r & ~active_o)) || (had_act_r && act_r == 4'h0));
		if (rst_i) begin
			dm1_send_o <= 1'b0;
			dm1_multi_o <= 1'b0;
			dm2_send_o <= 1'b0;
			lamp_o <= 8'h00;
			active_o <= 4'h0;
			prev_o <= 4'h0;
			had_act_r <= 1'b0;
			pend_r <= 1'b0;
			tx_r <= TX_IDLE;
		end else begin
			active_o <= act_r;
			prev_o <= prv_r;
			had_act_r <= |act_r;
			// no dm1 send before hold-off
			// a request right behind a send is owed, not lost,
			// so the strobe stays a one-cycle pulse
			dm1_send_o <= (go || pend_r) && !dm1_send_o;
			pend_r <= (go || pend_r) && dm1_send_o;
			dm2_send_o <= req_r[REQ_DM2_BIT];
			case (tx_r)
				TX_IDLE: begin
					if (go) begin
						tx_r <= (n > 1) ? TX_MULTI : TX_SINGLE;
					end
				end
				TX_SINGLE, TX_MULTI: begin
					if (!tx_busy_i && !go) begin
						tx_r <= TX_IDLE;
					end
				end
				default: tx_r <= TX_IDLE;
			endcase
			if (go) begin
				dm1_multi_o <= n > 1;
			end
			// lamp bits; zero when none active
			lamp_o <= 8'h00;
			for (int i = 0; i < NBLK; i++) begin
				if (act_r[i]) begin
					case (cfg_r[i][CFG_LAMP_LSB +: 2])
						2'd0: lamp_o[1:0] <= 2'b01;
						2'd1: lamp_o[3:2] <= 2'b01;
						2'd2: lamp_o[5:4] <= 2'b01;
						default: lamp_o[7:6] <= 2'b01;
					endcase
				end
			end
		end
	end

	// shut pulse output on supply or temperature
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_disable_o <= 1'b0;
		end else begin
			out_disable_o <= (ctrl_r[CTRL_PWR_OFF_BIT] & raw_r[BLK_SUPPLY]) |
				(ctrl_r[CTRL_TEMP_OFF_BIT] & raw_r[BLK_TEMP]);
		end
	end
endmodule

// ### sim/can_net_model.sv
`timescale 1ns/1ps
// far-side network: other units send the watched message now and then,
// and the transport stays busy for a while after each hand-over
module can_net_model #(
	parameter int GAP = 20, // cycles between received messages
	parameter int BUSY = 6 // transport cycles per message, slow answer
) (
	input wire logic clk_i, // clock
	input wire logic talk_i, // other units are sending
	input wire logic send_i, // a message was handed over
	output logic rx_seen_o, // message arrived, pulse
	output logic tx_busy_o // transport busy
);
	int gap_r = 0; // cycles to next arrival
	int busy_r = 0; // transport cycles left
	initial begin
		rx_seen_o = 1'b0;
		tx_busy_o = 1'b0;
	end
	// arrivals and transport occupancy
	always @(posedge clk_i) begin
		rx_seen_o <= talk_i && gap_r == 0;
		gap_r <= (gap_r == 0) ? GAP : gap_r - 1;
		busy_r <= send_i ? BUSY : (busy_r > 0 ? busy_r - 1 : 0);
		tx_busy_o <= send_i || busy_r > 1;
	end
endmodule

// ### sim/diag_properties.sv
`timescale 1ns/1ps
// watches bus handshake and message strobes at the top ports
module diag_properties #(
	parameter longint HOLDOFF = 200 // power-up hold-off cycles
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset
	input wire logic [5:0] adr_i, // address
	input wire logic [31:0] dat_i, // write data
	input wire logic [3:0] sel_i, // byte enables
	input wire logic we_i, // write
	input wire logic cyc_i, // cycle
	input wire logic stb_i, // strobe
	input wire logic ack_o, // acknowledge
	input wire logic dm1_send_o, // active-code send
	input wire logic dm2_send_o // prev-code send
);
	import diag_pkg::*;
	logic [31:0] up_r; // cycles since reset, saturating
	logic dm2_wr; // a taken write of the dm2 request bit
	assign dm2_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0]
		&& adr_i == OFS_REQ && dat_i[REQ_DM2_BIT];
	// age since reset; saturates so a long run never wraps
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			up_r <= '0;
		end else if (up_r != 32'hFFFF_FFFF) begin
			up_r <= up_r + 32'h1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	dm1_pulse_a: assert property (dm1_send_o |=> !dm1_send_o)
		else $error("dm1 strobe not a pulse");
	dm2_pulse_a: assert property (dm2_send_o |=> !dm2_send_o)
		else $error("dm2 strobe not a pulse");
	// slack of two cycles allows for the counter's own latency
	holdoff_quiet_a: assert property (up_r < HOLDOFF - 2 |-> !dm1_send_o)
		else $error("dm1 sent during hold-off");
	dm2_cause_a: assert property (dm2_send_o |->
		$past(dm2_wr, 2) || $past(dm2_wr, 3))
		else $error("dm2 sent without request");
	dm2_answer_a: assert property (dm2_wr |-> ##[1:3] dm2_send_o)
		else $error("dm2 request not answered");
endmodule

bind fault_diag_manager diag_properties #(.HOLDOFF(HOLDOFF)) chk (
	.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
	.sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .dm1_send_o(dm1_send_o), .dm2_send_o(dm2_send_o));

// ### sim/tb.sv
`timescale 1ns/1ps
// bench: drives bus and measured levels, compares with its own model
module tb;
	import diag_pkg::*;
	localparam int HO = 200; // shortened hold-off
	localparam int PER = 50; // shortened broadcast period
	logic clk_i = 1'b0; // clock
	logic rst_i = 1'b1; // reset
	logic [5:0] adr_i = '0; // bus address
	logic [31:0] dat_i = '0; // bus write data
	logic [3:0] sel_i = '0; // byte enables
	logic we_i = 1'b0; // write
	logic cyc_i = 1'b0; // cycle
	logic stb_i = 1'b0; // strobe
	logic [15:0] supply_i = 16'h0008; // supply level
	logic [15:0] temp_i = 16'h0000; // temperature, kept cool
	logic [15:0] target_i = 16'h0064; // output target
	logic [15:0] feedback_i = 16'h0064; // output feedback
	logic [31:0] dat_o, q, spn; // read data, read word, chosen spn
	logic ack_o, rx_seen, tx_busy, out_disable_o, dm1_send_o, dm1_multi_o;
	logic dm2_send_o; // prev-code send
	logic [7:0] lamp_o; // lamp byte
	logic [3:0] active_o, prev_o; // code states
	logic [15:0] tgt; // random target
	int error_cnt = 0; // mismatches
	int tests_run = 0; // comparisons
	int cycles = 0; // hang guard
	int gap = 0; // cycles since last broadcast
	logic talk = 1'b1; // other units still sending
	int exp_oc[NBLK]; // model occurrence counts
	always #2 clk_i = ~clk_i;
	fault_diag_manager #(.HOLDOFF(HO), .PERIOD(PER)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
		.we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
		.ack_o(ack_o), .supply_i(supply_i), .temp_i(temp_i),
		.target_i(target_i), .feedback_i(feedback_i), .rx_seen_i(rx_seen),
		.tx_busy_i(tx_busy), .out_disable_o(out_disable_o),
		.dm1_send_o(dm1_send_o), .dm1_multi_o(dm1_multi_o),
		.dm2_send_o(dm2_send_o), .lamp_o(lamp_o), .active_o(active_o),
		.prev_o(prev_o));
	can_net_model net (.clk_i(clk_i), .talk_i(talk),
		.send_i(dm1_send_o || dm2_send_o), .rx_seen_o(rx_seen),
		.tx_busy_o(tx_busy));
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one classic cycle; waits for ack, never assumes its latency
	task automatic wb(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		check("bus ack", ack_o, 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic wait_bit(int b, logic v);
		int n;
		n = 0;
		while (active_o[b] !== v && n < 6000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	function automatic logic [31:0] cfg(logic [31:0] s, int f, int l, int k);
		return s | f << CFG_FMI_LSB | l << CFG_LAMP_LSB | 1 << CFG_GEN_BIT
			| k << CFG_LATCH_BIT | 1 << CFG_EN_BIT;
	endfunction
	// hang guard; with generation on, broadcasts must keep coming
	always @(posedge clk_i) begin
		cycles++;
		gap = dm1_send_o ? 0 : gap + 1;
		if (cycles > HO + PER && gap == PER + 20)
			check("dm1 period", 32'h0, 32'h1);
		if (cycles == 30000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(33335));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		check("reset", {active_o, prev_o, lamp_o, out_disable_o}, '0);
		spn = $urandom & 32'h7FFFF;
		wb(1, OFS_CTRL, 32'h1, q);
		wb(1, OFS_THR0, 32'h0010_0000, q);
		// block 3 low half is the shared clear band
		wb(1, OFS_THR0 + 6'hC, 32'h0000_0004, q);
		wb(1, 6'h3C, 32'h0, q);
		wb(1, OFS_CFG0, cfg(spn, 4, 1, 0), q);
		wb(1, OFS_CFG0 + 6'h8, cfg(spn + 1, 9, 1, 0), q);
		wb(0, OFS_CFG0, 0, q);
		check("cfg0", q & 32'h1FFF_FFFF, cfg(spn, 4, 1, 0));
		wb(0, OFS_DTC0, 0, q);
		check("dtc0 new", q & 32'hFFFF_E0FF, spn << 13);
		$display("config test done");
		repeat (HO) @(posedge clk_i);
		supply_i <= 16'h0020;
		repeat (100) @(posedge clk_i);
		check("persist", active_o, 4'h0);
		wait_bit(0, 1'b1);
		repeat (2) @(posedge clk_i);
		exp_oc[0]++;
		check("active", active_o, 4'h1);
		check("out off", out_disable_o, 1'b1);
		check("lamp amber", lamp_o, 8'h04);
		wb(0, OFS_DTC0, 0, q);
		check("dtc0 hi", q, 32'(spn << 13 | 3 << 8 | exp_oc[0]));
		supply_i <= 16'h000E;
		repeat (20) @(posedge clk_i);
		check("band", active_o, 4'h1);
		supply_i <= 16'h0008;
		wait_bit(0, 1'b0);
		repeat (2) @(posedge clk_i);
		check("prev", {active_o, prev_o}, 8'h01);
		wb(1, OFS_REQ, 32'h2, q);
		repeat (4) @(posedge clk_i);
		check("dm3", prev_o, 4'h0);
		wb(1, OFS_REQ, 32'h1, q);
		@(posedge clk_i);
		check("dm2 sent", dm2_send_o, 1'b1);
		spn = $urandom & 32'h7FFFF;
		wb(1, OFS_CFG0, cfg(spn, 4, 1, 0), q);
		exp_oc[0] = 0;
		wb(0, OFS_DTC0, 0, q);
		check("oc reset", q & 32'h7F, exp_oc[0]);
		$display("supply test done");
		wb(1, OFS_CFG0 + 6'hC, cfg(spn, 7, 2, 1), q);
		tgt = 16'h0100 + 16'($urandom % 256);
		target_i <= tgt;
		feedback_i <= tgt - 16'h5;
		wait_bit(3, 1'b1);
		repeat (2) @(posedge clk_i);
		check("out fault", active_o, 4'h8);
		check("lamp red", lamp_o, 8'h10);
		feedback_i <= tgt;
		repeat (20) @(posedge clk_i);
		check("latched", active_o, 4'h8);
		wb(1, OFS_REQ, 32'h4, q);
		repeat (4) @(posedge clk_i);
		check("dm11", active_o, 4'h0);
		check("lamp none", lamp_o, 8'h00);
		$display("output test done");
		wb(1, 6'h3C, 32'h0000_0028, q);
		repeat (60) @(posedge clk_i);
		check("comm kept", active_o[2], 1'b0);
		talk <= 1'b0;
		wait_bit(2, 1'b1);
		repeat (2) @(posedge clk_i);
		check("comm lost", active_o, 4'h4);
		feedback_i <= tgt - 16'h5;
		wait_bit(3, 1'b1);
		repeat (2) @(posedge clk_i);
		check("multi", dm1_multi_o, 1'b1);
		$display("comm test done");
		complete_run();
	end
endmodule
